/* File: logic/lfs_supervisor.sv */
/*
 * Fault supervision and shutdown control of a four-string boost LED driver.
 * Assumes enable and dimming inputs synchronous to core_clk and analog
 * comparators already resolved to clean logic levels.
 */
`default_nettype none
// Overview of operation
// [R01] Enable low beyond 16 ms puts device to sleep, bias supply off.
// [R02] Enable rising after sleep clears latched faults; soft start on dimming high.
// [R03] Enable high, dimming low beyond 16 ms clears latched faults, no sleep.
// [R04] After such a clear, next dimming rise still runs full soft start.
// [R05] Bias supply and switching clock output stay on while enable is high.
// [R06] Sink pin above short threshold drops its channel out of regulation.
// [R07] Standard variant pulls fault low on string short until long-low clear.
// [R08] Alternate variant disables shorted channel but leaves fault output high.
// [R09] Short detection armed only while some sink pin sits at regulation.
// [R10] Overvoltage sense trip registers an output overvoltage event.
// [R11] Output overvoltage stops switching only; no latch, no fault output. The code also latches currentless sinks off until a fault clear.
// [R12] Overvoltage drops currentless strings; switching resumes below 97 percent.
// [R13] Secondary overvoltage disables switching and sinks, latched until reset.
// [R14] Cycle current limit ends the cycle and skips one, not latched.
// [R15] Secondary switch current limit shuts down at once and latches.
// [R16] Low-time measurement restarts whenever the input returns high early.
module lfs_supervisor #(
	parameter int unsigned LOW_CYCLES = lfs_pkg::LOW_TIME_CYCLES,
	parameter bit ALTERNATE_VARIANT = 1'b0
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic reset_n,
	// Host pins.
	input wire logic enable_in,
	input wire logic dimming_in,
	// Comparator inputs.
	input wire lfs_pkg::lfs_sink_s [lfs_pkg::NUM_STRINGS-1:0] sink_in,
	input wire lfs_pkg::lfs_boost_s boost_in,
	input wire logic cycle_boundary,
	input wire logic soft_start_done,
	// Controls and status.
	output logic bias_enable,
	output logic switching_clock_enable,
	output logic boost_enable,
	output logic soft_start,
	output logic [lfs_pkg::NUM_STRINGS-1:0] sink_enable,
	output logic fault_out_oe,
	output logic overvoltage_event,
	output logic latched_off
);
	import lfs_pkg::*;

	if (LOW_CYCLES < 2)
	begin : g_low_cycles_check
		$error("LOW_CYCLES too small");
	end

	lfs_state_e state_q;
	logic en_long_low;
	logic dim_long_low;
	logic en_prev_q;
	logic dim_prev_q;
	logic clear_faults;
	logic [NUM_STRINGS-1:0] short_q;
	logic [NUM_STRINGS-1:0] open_q;
	logic short_flag_q;
	logic ovp_q;
	logic skip_q;
	logic sleep_q;
	logic armed;
	logic [NUM_STRINGS-1:0] reg_vec;
	logic hard_trip;

	////////////////////////////////////////////////////////////////////////////
	// Long-low timers on the host pins.
	lfs_low_timer #(.CYCLES(LOW_CYCLES)) u_en_timer (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.level_in(enable_in),
		.expired(en_long_low)
	);
	lfs_low_timer #(.CYCLES(LOW_CYCLES)) u_dim_timer (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.level_in(dimming_in),
		.expired(dim_long_low)
	);

	// Edge history of the host pins.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			en_prev_q <= 1'b0;
			dim_prev_q <= 1'b0;
		end
		else
		begin
			en_prev_q <= enable_in;
			dim_prev_q <= dimming_in;
		end
	end

	// Fault clear on waking from sleep or on a long dimming-low with enable high.
	assign clear_faults = (sleep_q && enable_in && !en_prev_q) // [R02]
		|| (enable_in && dim_long_low); // [R03]

	////////////////////////////////////////////////////////////////////////////
	// Sleep tracking; the wake edge wins because the expiry flag lags the pin a cycle.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			sleep_q <= SLEEP_RESET;
		else if (enable_in && !en_prev_q)
			sleep_q <= 1'b0; // [R02]
		else if (en_long_low)
			sleep_q <= 1'b1; // [R01]
	end

	// Operating sequence; every clear falls back to idle so a soft start follows.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			state_q <= LFS_SLEEP;
		else
		begin
			unique case (state_q)
				LFS_SLEEP:
					if (enable_in && !en_prev_q)
						state_q <= LFS_IDLE; // [R02]
				LFS_IDLE:
					if (en_long_low)
						state_q <= LFS_SLEEP;
					else if (enable_in && dimming_in && !dim_prev_q)
						state_q <= LFS_SOFT_START; // [R02] [R04]
				LFS_SOFT_START:
					if (en_long_low)
						state_q <= LFS_SLEEP;
					else if (clear_faults)
						state_q <= LFS_IDLE;
					else if (soft_start_done)
						state_q <= LFS_RUN;
				LFS_RUN:
					if (en_long_low)
						state_q <= LFS_SLEEP; // [R01]
					else if (clear_faults)
						state_q <= LFS_IDLE; // [R04]
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Short detection needs at least one sink at regulation.
	always_comb
	begin
		for (int i = 0; i < NUM_STRINGS; i++)
			reg_vec[i] = sink_in[i].at_regulation;
		armed = |reg_vec; // [R09]
	end

	// Per-string short and open latches; detection wins over a clear.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			short_q <= '0;
			open_q <= '0;
		end
		else
		begin
			for (int i = 0; i < NUM_STRINGS; i++)
			begin
				if (state_q == LFS_RUN && armed && sink_in[i].above_short)
					short_q[i] <= 1'b1; // [R06] [R09]
				else if (clear_faults || en_long_low)
					short_q[i] <= 1'b0; // [R07]
				if (boost_in.output_overvoltage_trip && sink_in[i].no_current)
					open_q[i] <= 1'b1; // [R12]
				else if (clear_faults)
					open_q[i] <= 1'b0;
			end
		end
	end

	// Fault flag for the standard variant only.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			short_flag_q <= FAULT_RESET;
		else if (!ALTERNATE_VARIANT && (|short_q))
			short_flag_q <= 1'b1; // [R07] [R08]
		else if (clear_faults || (!enable_in && en_long_low))
			short_flag_q <= 1'b0; // [R07]
	end

	////////////////////////////////////////////////////////////////////////////
	// Output overvoltage holds off switching until below the resume level.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			ovp_q <= 1'b0;
		else if (boost_in.output_overvoltage_trip)
			ovp_q <= 1'b1; // [R10] [R11]
		else if (boost_in.output_below_resume)
			ovp_q <= 1'b0; // [R12]
	end

	// Cycle limit skips the rest of this cycle and the whole next one.
	logic skip_next_q;
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			skip_q <= 1'b0;
			skip_next_q <= 1'b0;
		end
		else if (boost_in.cycle_current_limit)
		begin
			skip_q <= 1'b1; // [R14]
			skip_next_q <= 1'b1;
		end
		else if (cycle_boundary)
		begin
			skip_q <= skip_next_q;
			skip_next_q <= 1'b0;
		end
	end

	// Hard latches from secondary overvoltage and current; trip wins over clear.
	assign hard_trip = boost_in.secondary_overvoltage_trip || boost_in.secondary_switch_limit;
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			latched_off <= 1'b0;
		else if (hard_trip)
			latched_off <= 1'b1; // [R13] [R15]
		else if (clear_faults)
			latched_off <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Registered outputs; the hard trips also gate directly for immediacy.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bias_enable <= 1'b0;
			switching_clock_enable <= 1'b0;
			boost_enable <= 1'b0;
			soft_start <= 1'b0;
			sink_enable <= '0;
			fault_out_oe <= 1'b0;
			overvoltage_event <= 1'b0;
		end
		else
		begin
			bias_enable <= enable_in || !sleep_q; // [R01] [R05]
			switching_clock_enable <= enable_in || !sleep_q; // [R05]
			boost_enable <= (state_q == LFS_SOFT_START || state_q == LFS_RUN) && dimming_in
				&& !ovp_q && !boost_in.output_overvoltage_trip && !skip_q
				&& !boost_in.cycle_current_limit && !latched_off
				&& !boost_in.secondary_overvoltage_trip
				&& !boost_in.secondary_switch_limit; // [R11] [R13] [R14] [R15]
			soft_start <= (state_q == LFS_SOFT_START);
			for (int i = 0; i < NUM_STRINGS; i++)
				sink_enable[i] <= (state_q == LFS_RUN) && dimming_in && !short_q[i] && !open_q[i]
					&& !latched_off && !boost_in.secondary_overvoltage_trip
					&& !boost_in.secondary_switch_limit; // [R06] [R12] [R13]
			fault_out_oe <= short_flag_q || latched_off;
			overvoltage_event <= ovp_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	sequence hard_trip_s;
		hard_trip;
	endsequence
	sleep_entry_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [R01]
		(en_long_low && !enable_in) ##1 !enable_in |=> !bias_enable) else $error("no sleep");
	wake_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [R02]
		(sleep_q && enable_in && !en_prev_q && !hard_trip) |=> !latched_off)
		else $error("wake did not clear faults");
	dim_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [R03]
		(enable_in && dim_long_low && !hard_trip) |=> !latched_off && !sleep_q)
		else $error("dimming low did not clear");
	bias_on_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [R05]
		enable_in |=> bias_enable && switching_clock_enable) else $error("bias dropped");
	short_off_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [R06]
		(|short_q) |=> !(|(sink_enable & $past(short_q)))) else $error("shorted sink still on");
	alt_fault_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [R08]
		(ALTERNATE_VARIANT && !latched_off) |=> !fault_out_oe) else $error("alternate flagged fault");
	ovp_quiet_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [R11]
		(ovp_q && !latched_off && !short_flag_q) |=> !boost_enable && !fault_out_oe)
		else $error("overvoltage misbehaved");
	hard_latch_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [R13] [R15]
		hard_trip_s |=> latched_off ##1 (!boost_enable && sink_enable == '0))
		else $error("hard trip not latched");
	skip_cycle_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [R14]
		(boost_in.cycle_current_limit && !latched_off && !hard_trip)
		|=> !boost_enable && !latched_off) else $error("cycle limit not handled");
endmodule : lfs_supervisor
`default_nettype wire

/* File: logic/lfs_pkg.sv */
/*
 * Shared constants and carrier types for the LED driver fault supervisor.
 * Assumes a single 100 MHz core clock; analog sensing arrives as comparator bits.
 */
`default_nettype none
package lfs_pkg;
	// Core clock period and the long-low supervision time.
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned LOW_TIME_MS = 16;
	localparam int unsigned LOW_TIME_CYCLES = (LOW_TIME_MS * 1000000) / CLK_PERIOD_NS;
	localparam int unsigned NUM_STRINGS = 4;
	// Reset values of the control state.
	localparam logic FAULT_RESET = 1'b0;
	localparam logic SLEEP_RESET = 1'b1;

	// Comparator inputs for one sink pin.
	typedef struct packed {
		logic above_short;
		logic at_regulation;
		logic no_current;
	} lfs_sink_s;

	// Switch-side comparator inputs.
	typedef struct packed {
		logic output_overvoltage_trip;
		logic output_below_resume;
		logic secondary_overvoltage_trip;
		logic cycle_current_limit;
		logic secondary_switch_limit;
	} lfs_boost_s;

	typedef enum logic [1:0] {
		LFS_SLEEP,
		LFS_IDLE,
		LFS_SOFT_START,
		LFS_RUN
	} lfs_state_e;
endpackage : lfs_pkg
`default_nettype wire

/* File: logic/lfs_low_timer.sv */
/*
 * Counts how long a monitored input has stayed low and flags expiry.
 * Assumes the input is synchronous to core_clk.
 */
`default_nettype none
module lfs_low_timer #(
	parameter int unsigned CYCLES = 1600000
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic reset_n,
	// Monitored level and expiry flag.
	input wire logic level_in,
	output logic expired
);
	import lfs_pkg::*;

	// Elaboration check: the expiry compare needs at least two counted cycles.
	if (CYCLES < 2)
	begin : g_cycles_check
		$error("lfs_low_timer needs at least two cycles");
	end

	logic [31:0] count_q;

	// Counting restarts from zero whenever the input returns high.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			count_q <= 32'h0;
		else if (level_in)
			count_q <= 32'h0; // [R16]
		else if (count_q < CYCLES)
			count_q <= count_q + 32'h1;
	end

	// Expiry as soon as the input has been low for the set low time.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			expired <= 1'b0;
		else
			expired <= !level_in && (count_q >= CYCLES - 1);
	end

	restart_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [R16]
		level_in |=> (count_q == 32'h0)) else $error("low timer did not restart");
endmodule : lfs_low_timer
`default_nettype wire

/* File: verification/lfs_host_model.sv */
/*
 * Host controller model: drives the enable and dimming pins, reads the fault pin.
 * Assumes the bench changes its commands only at rising edges of core_clk.
 */
`default_nettype none
module lfs_host_model (
	// Clock.
	input wire logic core_clk,
	// Commands from the bench.
	input wire logic enable_cmd,
	input wire logic dimming_cmd,
	// Pins of the supervisor.
	input wire logic fault_out_oe,
	output var logic enable_in = 1'b0,
	output var logic dimming_in = 1'b0,
	output logic fault_n
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pins follow a command one edge later, as a host port register would.
	always @(posedge core_clk)
	begin
		enable_in <= enable_cmd;
		dimming_in <= dimming_cmd;
	end
	// Open-drain fault line with a pull-up, so a released pin reads high.
	assign fault_n = fault_out_oe ? 1'b0 : 1'b1;
endmodule : lfs_host_model
`default_nettype wire

/* File: verification/tb_top.sv */
/*
 * Self-checking bench for the fault supervisor, standard and alternate variant.
 * Assumes a shortened long-low time of 20 cycles and a 4-cycle switching period.
 */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import lfs_pkg::*;
	localparam int unsigned LOW = 20;
	localparam int BIAS = 0, CLKO = 1, BOOST = 2, SOFT = 3, SINKS = 4;
	localparam int FAULT = 5, OVEV = 6, LATCH = 7, ALTF = 8, ALTS = 9;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic enable_cmd = 1'b0, dimming_cmd = 1'b0, cycle_boundary = 1'b0, soft_start_done = 1'b0;
	logic [1:0] cyc_q = 2'h0;
	lfs_sink_s [NUM_STRINGS-1:0] sink_in = {4{3'b010}};
	lfs_boost_s boost_in = '0;
	logic enable_in, dimming_in, fault_n, alt_oe, bias_enable, switching_clock_enable;
	logic boost_enable, soft_start, fault_out_oe, overvoltage_event, latched_off;
	logic [3:0] sink_enable, alt_sink;
	int fail_count = 0;
	int checked = 0;
	////////////////////////////////////////////////////////////////////////////////
	// Clock, and a switching-cycle start every fourth cycle.
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cyc_q <= cyc_q + 2'h1;
		cycle_boundary <= (cyc_q == 2'h3);
	end
	lfs_host_model u_host (.core_clk, .enable_cmd, .dimming_cmd, .fault_out_oe, .enable_in,
		.dimming_in, .fault_n);
	lfs_supervisor #(.LOW_CYCLES(LOW)) u_dut (.core_clk, .reset_n, .enable_in, .dimming_in,
		.sink_in, .boost_in, .cycle_boundary, .soft_start_done, .bias_enable,
		.switching_clock_enable, .boost_enable, .soft_start, .sink_enable, .fault_out_oe,
		.overvoltage_event, .latched_off);
	// The alternate variant shares every input so the two can be compared on a short.
	lfs_supervisor #(.LOW_CYCLES(LOW), .ALTERNATE_VARIANT(1'b1)) u_alt (.core_clk, .reset_n,
		.enable_in, .dimming_in, .sink_in, .boost_in, .cycle_boundary, .soft_start_done,
		.bias_enable(), .switching_clock_enable(), .boost_enable(), .soft_start(),
		.sink_enable(alt_sink), .fault_out_oe(alt_oe), .overvoltage_event(), .latched_off());
	////////////////////////////////////////////////////////////////////////////////
	// One selector per observed output keeps the wait and hold tasks shared.
	function automatic logic [3:0] probe(input int sel);
		case (sel)
			BIAS: return {3'h0, bias_enable};
			CLKO: return {3'h0, switching_clock_enable};
			BOOST: return {3'h0, boost_enable};
			SOFT: return {3'h0, soft_start};
			SINKS: return sink_enable;
			FAULT: return {3'h0, fault_n};
			OVEV: return {3'h0, overvoltage_event};
			LATCH: return {3'h0, latched_off};
			ALTF: return {3'h0, alt_oe};
			default: return alt_sink;
		endcase
	endfunction : probe

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	// Bounded wait; running out of cycles ends the run at once.
	task automatic await(input int sel, input logic [3:0] exp, input int n);
		int i;
		for (i = 0; i < n; i++)
		begin
			@(posedge core_clk);
			#1;
			if (probe(sel) === exp)
				break;
		end
		checked++;
		if (i == n)
		begin
			$display("unexpected at %0t: output %0d never reached %h", $time, sel, exp);
			fail_count++;
			print_verdict();
		end
	endtask : await

	// The output must keep its value on each of the next n edges.
	task automatic hold(input int sel, input logic [3:0] exp, input int n);
		checked++;
		repeat (n)
		begin
			@(posedge core_clk);
			#1;
			if (probe(sel) !== exp)
			begin
				$display("unexpected at %0t: output %0d left %h", $time, sel, exp);
				fail_count++;
				return;
			end
		end
	endtask : hold

	task automatic drive(input logic en, input logic dim);
		@(posedge core_clk);
		enable_cmd <= en;
		dimming_cmd <= dim;
	endtask : drive
	////////////////////////////////////////////////////////////////////////////////
	// Enable, then dimming, then soft start completion, ending with all strings on.
	task automatic bring_up();
		drive(1'b1, 1'b0);
		await(BIAS, 4'h1, 6);
		await(CLKO, 4'h1, 2);
		drive(1'b1, 1'b1);
		await(SOFT, 4'h1, 6);
		@(posedge core_clk) soft_start_done <= 1'b1;
		@(posedge core_clk) soft_start_done <= 1'b0;
		await(SINKS, 4'hf, 4);
	endtask : bring_up

	// A short on string 1 with string 0 at regulation, then a long dimming-low clear.
	task automatic short_and_clear();
		@(posedge core_clk) sink_in[1] <= 3'b100;
		await(SINKS, 4'hd, 4);
		await(FAULT, 4'h0, 4);
		await(ALTS, 4'hd, 4);
		hold(ALTF, 4'h0, 4);
		hold(SINKS, 4'hd, 4);
		@(posedge core_clk) sink_in <= {4{3'b010}};
		hold(FAULT, 4'h0, 3);
		drive(1'b1, 1'b0);
		hold(FAULT, 4'h0, LOW - 4);
		await(FAULT, 4'h1, 8);
		hold(BIAS, 4'h1, 2);
		hold(CLKO, 4'h1, 1);
		bring_up();
	endtask : short_and_clear

	// Output overvoltage with string 3 carrying no current, then hysteresis.
	task automatic overvoltage();
		@(posedge core_clk);
		boost_in.output_overvoltage_trip <= 1'b1;
		sink_in[3].no_current <= 1'b1;
		await(OVEV, 4'h1, 4);
		await(BOOST, 4'h0, 2);
		await(SINKS, 4'h7, 4);
		hold(LATCH, 4'h0, 2);
		hold(FAULT, 4'h1, 2);
		@(posedge core_clk) boost_in.output_overvoltage_trip <= 1'b0;
		hold(BOOST, 4'h0, 4);
		@(posedge core_clk) boost_in.output_below_resume <= 1'b1;
		await(BOOST, 4'h1, 4);
		@(posedge core_clk) boost_in <= '0;
	endtask : overvoltage

	// One cycle-limit hit: the rest of the cycle plus one cycle off, never latched.
	task automatic cycle_limit();
		@(posedge core_clk) boost_in.cycle_current_limit <= 1'b1;
		@(posedge core_clk) boost_in.cycle_current_limit <= 1'b0;
		await(BOOST, 4'h0, 3);
		hold(BOOST, 4'h0, 3);
		await(BOOST, 4'h1, 10);
		hold(LATCH, 4'h0, 1);
	endtask : cycle_limit

	// Both hard trips latch off, and sleep followed by enable clears them.
	task automatic hard_trips();
		for (int k = 0; k < 2; k++)
		begin
			@(posedge core_clk);
			boost_in.secondary_overvoltage_trip <= (k == 0);
			boost_in.secondary_switch_limit <= (k == 1);
			@(posedge core_clk) boost_in <= '0;
			await(LATCH, 4'h1, 3);
			hold(SINKS, 4'h0, 4);
			hold(BOOST, 4'h0, 1);
			drive(1'b0, 1'b0);
			hold(BIAS, 4'h1, LOW - 4);
			await(BIAS, 4'h0, 8);
			bring_up();
			hold(LATCH, 4'h0, 1);
		end
	endtask : hard_trips
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial
	begin
		hold(BIAS, 4'h0, 3);
		hold(SINKS, 4'h0, 3);
		@(posedge core_clk) reset_n <= 1'b1;
		hold(BIAS, 4'h0, 3);
		bring_up();
		@(posedge core_clk) sink_in <= {3'b000, 3'b100, 3'b000, 3'b000};
		hold(SINKS, 4'hf, 6);
		hold(FAULT, 4'h1, 1);
		@(posedge core_clk) sink_in <= {4{3'b010}};
		short_and_clear();
		overvoltage();
		cycle_limit();
		// Two low stretches each shorter than the limit must not add up to sleep.
		drive(1'b0, 1'b1);
		hold(BIAS, 4'h1, LOW - 6);
		drive(1'b1, 1'b1);
		drive(1'b0, 1'b1);
		hold(BIAS, 4'h1, LOW - 6);
		drive(1'b1, 1'b1);
		hard_trips();
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
